// >>> verilog/wdtrl_core.v
// Watchdog timer with reload, reached over the CPU special-register port.
// Assumes one clock, a synchronous reset for every source, an instruction
// strobe from the core and a low-speed oscillator level on a pin.
`timescale 1ns/1ps
`default_nettype none
`include "wdtrl_consts.vh"

module wdtrl_core (
	input  wire       clk,
	input  wire       rst,
	input  wire       por,
	input  wire       sfr_wr,
	input  wire       sfr_rd,
	input  wire [7:0] sfr_addr,
	input  wire [7:0] sfr_wdata,
	input  wire       instr_done,
	input  wire       idle_mode,
	input  wire       power_down,
	input  wire       low_speed_rc_osc,
	output reg  [7:0] sfr_rdata,
	output reg        wdog_reset_req,
	output reg        wdog_wake
);

////////////////////////////////////////////////////////////////////////////////

	reg  [7:0]  reload_ff;
	reg  [7:0]  ctrl_ff;
	reg  [7:0]  interrupt_enable_first_ff;
	reg  [7:0]  interrupt_enable_second_ff;
	reg  [7:0]  ip0_ff;
	reg         arm_ff;
	reg         arm_age_ff;
	reg  [15:0] cnt_ff;
	reg  [3:0]  pre_ff;
	reg  [3:0]  sysdiv_ff;
	reg         low_speed_rc_osc_s1_ff;
	reg         low_speed_rc_osc_s2_ff;
	reg         low_speed_rc_osc_d_ff;
	reg  [7:0]  nxt_rdata;

	wire        wr_reload = sfr_wr && (sfr_addr == `WDTRL_ADDR_RELOAD);
	wire        wr_ctrl   = sfr_wr && (sfr_addr == `WDTRL_ADDR_CTRL);
	wire        wr_interrupt_enable_first   = sfr_wr && (sfr_addr == `WDTRL_ADDR_INTERRUPT_ENABLE_FIRST);
	wire        wr_interrupt_enable_second   = sfr_wr && (sfr_addr == `WDTRL_ADDR_INTERRUPT_ENABLE_SECOND);
	wire        wr_ip0    = sfr_wr && (sfr_addr == `WDTRL_ADDR_IP0);
	wire [4:0]  wr_key    = sfr_wdata[`WDTRL_KEY_HI:`WDTRL_KEY_LO];
	wire [4:0]  cur_key   = ctrl_ff[`WDTRL_KEY_HI:`WDTRL_KEY_LO];
	wire        enabled   = (cur_key == `WDTRL_KEY_ENABLE);
	wire        set_arm   = wr_interrupt_enable_first && sfr_wdata[`WDTRL_BIT_ARM];
	wire        set_conf  = wr_interrupt_enable_second && sfr_wdata[`WDTRL_BIT_CONFIRM];
	// Confirm counts only if arm was set in this or the previous instruction
	wire        refresh   = set_conf && arm_ff && !arm_age_ff; // [R02]
	wire        bad_conf  = set_conf && !refresh; // [R14]
	wire        arm_stale = arm_ff && arm_age_ff && instr_done; // [R14]
	wire        bad_key   = wr_ctrl && (wr_key != `WDTRL_KEY_ENABLE)
	                        && (wr_key != `WDTRL_KEY_DISABLE); // [R05]
	wire        low_speed_rc_osc_rise = low_speed_rc_osc_s2_ff && !low_speed_rc_osc_d_ff;
	wire        src_tick  = ctrl_ff[`WDTRL_BIT_CSEL] ? (sysdiv_ff == `WDTRL_SYSDIV)
	                                                 : low_speed_rc_osc_rise; // [R06]
	// Oscillators are stopped in power-down, so neither prescaler nor counter counts there
	wire        cnt_tick  = enabled && !power_down && src_tick
	                        && (pre_ff == `WDTRL_PRESCALE); // [R12] [R16] [R10]
	wire        overflow  = cnt_tick && (cnt_ff == 16'hffff); // [R01]
	// Watchdog timeouts and bad refresh sequences both raise the flag
	wire        wd_event  = overflow || bad_conf || arm_stale;

////////////////////////////////////////////////////////////////////////////////
// Low-speed oscillator synchroniser and dividers

	always @(posedge clk) begin
		if (rst) begin
			low_speed_rc_osc_s1_ff <= 1'b0;
			low_speed_rc_osc_s2_ff <= 1'b0;
			low_speed_rc_osc_d_ff  <= 1'b0;
			sysdiv_ff  <= 4'h0;
			pre_ff     <= 4'h0;
		end else begin
			low_speed_rc_osc_s1_ff <= low_speed_rc_osc;
			low_speed_rc_osc_s2_ff <= low_speed_rc_osc_s1_ff;
			low_speed_rc_osc_d_ff  <= low_speed_rc_osc_s2_ff;
			sysdiv_ff  <= sysdiv_ff + 4'h1; // [R06]
			if (!enabled || power_down)
				pre_ff <= 4'h0;
			else if (src_tick)
				pre_ff <= pre_ff + 4'h1; // [R12]
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Counter

	always @(posedge clk) begin
		if (rst) begin
			cnt_ff <= 16'h0000;
		end else if (refresh) begin
			cnt_ff <= {reload_ff, 8'h00}; // [R04] [R15] [R13]
		end else if (cnt_tick) begin
			cnt_ff <= cnt_ff + 16'h0001; // [R01]
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Registers

	always @(posedge clk) begin
		if (rst) begin
			ctrl_ff <= `WDTRL_RST_CTRL; // [R07]
		end else if (wr_ctrl) begin
			ctrl_ff <= {wr_key, 2'b00, sfr_wdata[`WDTRL_BIT_CSEL]}; // [R09]
		end
	end

	// Power-on only: these survive watchdog and other resets
	always @(posedge clk) begin
		if (por) begin
			reload_ff  <= `WDTRL_RST_RELOAD; // [R11]
			interrupt_enable_first_ff    <= `WDTRL_RST_IEN;
			interrupt_enable_second_ff    <= `WDTRL_RST_IEN;
			ip0_ff     <= `WDTRL_RST_IP0;
			arm_ff     <= 1'b0;
			arm_age_ff <= 1'b0;
		end else begin
			if (wr_reload)
				reload_ff <= sfr_wdata;
			if (wr_interrupt_enable_first)
				interrupt_enable_first_ff <= {sfr_wdata[7], 1'b0, sfr_wdata[5:0]};
			if (wr_interrupt_enable_second)
				interrupt_enable_second_ff <= {sfr_wdata[7], 1'b0, 1'b0, sfr_wdata[4:0]};
			// Set wins over a software clear in the same cycle
			if (wd_event)
				ip0_ff <= {1'b0, 1'b1, (wr_ip0 ? sfr_wdata[5:0] : ip0_ff[5:0])}; // [R08]
			else if (wr_ip0)
				ip0_ff <= {1'b0, sfr_wdata[6:0]};
			if (refresh || bad_conf || arm_stale) begin
				arm_ff     <= 1'b0; // [R03] [R13]
				arm_age_ff <= 1'b0;
			end else if (set_arm) begin
				arm_ff     <= 1'b1;
				arm_age_ff <= 1'b0;
			end else if (arm_ff && instr_done) begin
				arm_age_ff <= 1'b1;
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Read data and reset outputs

	always @* begin
		case (sfr_addr)
			`WDTRL_ADDR_RELOAD: nxt_rdata = reload_ff;
			`WDTRL_ADDR_CTRL:   nxt_rdata = ctrl_ff; // [R09]
			`WDTRL_ADDR_INTERRUPT_ENABLE_FIRST:   nxt_rdata = interrupt_enable_first_ff; // [R03]
			`WDTRL_ADDR_INTERRUPT_ENABLE_SECOND:   nxt_rdata = interrupt_enable_second_ff;
			`WDTRL_ADDR_IP0:    nxt_rdata = ip0_ff;
			default:            nxt_rdata = 8'h00;
		endcase
	end

	always @(posedge clk) begin
		if (rst) begin
			sfr_rdata      <= 8'h00;
			wdog_reset_req <= 1'b0;
			wdog_wake      <= 1'b0;
		end else begin
			sfr_rdata      <= sfr_rd ? nxt_rdata : 8'h00;
			wdog_reset_req <= wd_event || bad_key; // [R01] [R05] [R14]
			wdog_wake      <= overflow && idle_mode; // [R10]
		end
	end

endmodule
`default_nettype wire

// >>> include/wdtrl_consts.vh
// Constants for the watchdog timer with reload: register addresses, fields,
// reset values. Assumes inclusion by the single watchdog design file.
// Functional notes
// [R01] Watchdog is a 16-bit counter; overflow causes a full reset.
// [R02] Software sets arm bit then confirm bit in the very next instruction.
// [R03] Arm bit clears itself in hardware and always reads zero.
// [R04] Completed refresh loads reload register into counter upper byte.
// [R05] Key 10101 disables, 01010 enables, any other written value resets.
// [R06] Clock select 0 picks low-speed RC, 1 picks system clock over 16.
// [R07] Control register returns to 0x50 after every reset source.
// [R08] Watchdog-reset flag set on watchdog reset; only software clears it (the code also clears it on power-on). A bad-key reset leaves it clear.
// [R09] Control bits 2 and 1 read as zero.
// [R10] Overflow in idle wakes via watchdog reset; no wake from power-down.
// [R11] Power-on clears reload, arm, confirm and watchdog-reset flag.
// [R12] Selected source is divided by 16 before counting.
// [R13] Refresh clears arm and confirm; larger reload means shorter timeout.
// [R14] Arm and confirm separated by more than one instruction gives a reset.
// [R15] Completed refresh also clears counter low byte.
// [R16] Disable key holds counter still and blocks overflow reset.
`ifndef WDTRL_CONSTS_VH
`define WDTRL_CONSTS_VH

`define WDTRL_ADDR_RELOAD  8'h86
`define WDTRL_ADDR_CTRL    8'h96
`define WDTRL_ADDR_INTERRUPT_ENABLE_FIRST    8'ha8
`define WDTRL_ADDR_INTERRUPT_ENABLE_SECOND    8'ha9
`define WDTRL_ADDR_IP0     8'hb8

`define WDTRL_RST_RELOAD   8'h00
`define WDTRL_RST_CTRL     8'h50
`define WDTRL_RST_IEN      8'h00
`define WDTRL_RST_IP0      8'h00

`define WDTRL_BIT_ARM      6
`define WDTRL_BIT_CONFIRM  6
`define WDTRL_BIT_FLAG     6
`define WDTRL_BIT_CSEL     0
`define WDTRL_KEY_HI       7
`define WDTRL_KEY_LO       3

`define WDTRL_KEY_DISABLE  5'h15
`define WDTRL_KEY_ENABLE   5'h0a

`define WDTRL_PRESCALE     4'hf
`define WDTRL_SYSDIV       4'hf

`endif

// >>> tb/wdtrl_assertions.sv
// Checker for the watchdog core: read masks, key decode, wake pulse.
// Assumes binding onto wdtrl_core, one clock, sync resets.
`timescale 1ns/1ps
`default_nettype none
module wdtrl_assertions (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       por,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       idle_mode,
	input wire logic       power_down,
	input wire logic [7:0] sfr_rdata,
	input wire logic       wdog_reset_req,
	input wire logic       wdog_wake
);
default clocking @(posedge clk); endclocking
default disable iff (rst || por);
wire bad_key = sfr_wr && sfr_addr == 8'h96 && sfr_wdata[7:3] != 5'h0a
	&& sfr_wdata[7:3] != 5'h15;
////////////////////////////////
AST_ARM_RD0: assert property (sfr_rd && sfr_addr == 8'ha8 |=> !sfr_rdata[6])
	else $error("arm bit read as one");
AST_CTRL_RD0: assert property (sfr_rd && sfr_addr == 8'h96 |=> sfr_rdata[2:1] == 2'h0)
	else $error("control bits 2:1 not zero");
AST_KEY_BAD: assert property (bad_key |=> wdog_reset_req)
	else $error("bad key gave no reset");
AST_RST_OUT: assert property (disable iff (1'b0) rst |=> !wdog_reset_req && !wdog_wake)
	else $error("outputs active after reset");
AST_WAKE: assert property (wdog_wake |-> $past(idle_mode))
	else $error("wake outside idle");
AST_PD: assert property (power_down && $past(power_down) |-> !wdog_wake)
	else $error("wake in power-down");
AST_WAKE_PULSE: assert property (wdog_wake |=> !wdog_wake)
	else $error("wake longer than one cycle");
AST_WAKE_RST: assert property (wdog_wake |-> wdog_reset_req)
	else $error("wake without reset request");
cover property (wdog_wake);
cover property (bad_key);
cover property (sfr_rd && sfr_addr == 8'hb8);
endmodule
bind wdtrl_core wdtrl_assertions u_chk (.clk, .rst, .por, .sfr_wr, .sfr_rd, .sfr_addr,
	.sfr_wdata, .idle_mode, .power_down, .sfr_rdata, .wdog_reset_req, .wdog_wake);
`default_nettype wire

// >>> tb/test_watchdog_timer_with_reload.sv
// Bench for the watchdog core over its register port.
// Assumes a 50 MHz clock; the bench toggles the slow oscillator every 8 clocks.
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_timer_with_reload;
logic       clk = 0, rst = 1, por = 1, wr = 0, rd = 0, ido = 0, idle = 0, pd = 0, osc = 0;
logic [7:0] a = 0, d = 0;
wire  [7:0] q;
wire        rq, wk;
int         err_total = 0, tests_run = 0, n_rq = 0, n_wk = 0, cyc = 0, cyc0 = 0;
wdtrl_core u_dut (.clk, .rst, .por, .sfr_wr(wr), .sfr_rd(rd), .sfr_addr(a), .sfr_wdata(d),
	.instr_done(ido), .idle_mode(idle), .power_down(pd), .low_speed_rc_osc(osc),
	.sfr_rdata(q), .wdog_reset_req(rq), .wdog_wake(wk));
always #10 clk = ~clk;
always @(posedge clk) begin
	cyc <= cyc + 1;
	// Slow oscillator: one rising edge every 16 clocks
	if (cyc[2:0] == 3'h0)
		osc <= ~osc;
	n_rq <= n_rq + rq;
	n_wk <= n_wk + wk;
	if (cyc > 90000) begin
		err_total++;
		final_report;
	end
end
////////////////////////////////
task chk(input logic [7:0] g, e);
	tests_run++;
	if (g !== e) begin
		err_total++;
		$display("BAD %0t got %h want %h", $time, g, e);
	end
endtask
task wrt(input logic [7:0] ad, dv);
	@(posedge clk);
	wr <= 1;
	a <= ad;
	d <= dv;
	@(posedge clk);
	wr <= 0;
endtask
task rdc(input logic [7:0] ad, e);
	@(posedge clk);
	rd <= 1;
	a <= ad;
	@(posedge clk);
	rd <= 0;
	#1 chk(q, e);
endtask
task rstp;
	@(posedge clk) rst <= 1;
	repeat (2) @(posedge clk);
	rst <= 0;
endtask
task final_report;
	$display("checks %0d errors %0d", tests_run, err_total);
	if (err_total == 0 && tests_run > 0)
		$display("RESULT: PASS");
	else
		$display("RESULT: FAIL");
	$finish;
endtask
////////////////////////////////
initial begin
	repeat (6) @(posedge clk);
	rst <= 0;
	por <= 0;
	rdc(8'h86, 8'h00);
	rdc(8'h96, 8'h50);
	rdc(8'hb8, 8'h00);
	wrt(8'h86, 8'hff);
	wrt(8'ha8, 8'hff);
	wrt(8'ha9, 8'hff);
	rdc(8'ha8, 8'hbf);
	rdc(8'ha9, 8'h9f);
	wrt(8'h96, 8'h57);
	rdc(8'h96, 8'h51);
	wrt(8'h96, 8'ha9);
	rdc(8'h96, 8'ha9);
	@(posedge clk) pd <= 1;
	repeat (3) @(posedge clk);
	pd <= 0;
	chk(n_rq[7:0], 8'h00);
	wrt(8'ha8, 8'h40);
	repeat (2) begin
		@(posedge clk) ido <= 1;
		@(posedge clk) ido <= 0;
	end
	repeat (3) @(posedge clk);
	chk(n_rq[7:0], 8'h01);
	rstp;
	rdc(8'hb8, 8'h40);
	rdc(8'h96, 8'h50);
	wrt(8'hb8, 8'h00);
	rdc(8'hb8, 8'h00);
	wrt(8'h96, 8'h00);
	repeat (2) @(posedge clk);
	chk(n_rq[7:0], 8'h02);
	rstp;
	wrt(8'h96, 8'h51);
	wrt(8'ha8, 8'h40);
	wrt(8'ha9, 8'h40);
	idle <= 1;
	cyc0 = cyc;
	while (n_rq < 3) @(posedge clk);
	chk({7'h0, cyc - cyc0 > 65000 && cyc - cyc0 < 66200}, 8'h01);
	chk(n_wk[7:0], 8'h01);
	rdc(8'hb8, 8'h40);
	final_report;
end
endmodule
`default_nettype wire
